// [core/odsb_bank.sv]
/*
 Diagnostic monitor page register bank: 256 byte page on a Wishbone
 slave, one byte per 32-bit word at byte address 4*offset.
 Assumes sensor values arrive already encoded on the clock domain;
 disable, fault and loss pins are asynchronous and are synchronised here.
*/
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
// How it works
// [R1] Temperature is signed 16 bits, 1/256 degC
// [R2] Supply is unsigned 16 bits, 100 uV
// [R3] Bias is unsigned 16 bits, 2 uA
// [R4] Transmit power unsigned 16 bits, 0.1 uW
// [R5] Receive power unsigned 16 bits, 0.1 uW
// [R6] Byte 95 is a fixed stored checksum
// [R7] Byte 127 writes acked, no effect
// [R8] Bytes 128 to 247 writable and retained
// [R9] Bytes 55 to 94 fixed defaults
// [R10] Status bit 7 shows disable pin level
// [R11] Bit 6 soft disable ORed with pin
// [R12] Rate select ignored; bit 4 reads full
// [R13] Status bit 2 mirrors transmit fault
// [R14] Status bit 1 mirrors signal loss
// [R15] Bit 0 low once readings are valid
// [R16] Byte 112 holds alarm flag pairs
// [R17] Byte 113 holds receive power alarms
// [R18] Byte 116 holds warning flag pairs
// [R19] Byte 117 holds receive power warnings
// [R20] Live readings at 96 to 105, MSB first
// [R21] Thresholds at 0 to 39, MSB first
// [R22] High above threshold, low below, temp signed
// [R23] Reserved reads zero; status writes ignored
module odsb_bank
   import odsb_pkg::*;
#(
   parameter int READY_CYC = ODSB_READY_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] temp_value,
   input wire logic [15:0] vcc_value,
   input wire logic [15:0] bias_value,
   input wire logic [15:0] txp_value,
   input wire logic [15:0] rxp_value,
   input wire logic tx_disable_pin,
   input wire logic rate_select_pin,
   input wire logic tx_fault_pin,
   input wire logic receive_signal_lost_output,
   output logic tx_off
);
   // ======================================================================
   // Storage
   // ======================================================================
   logic [7:0] thr_r [0:39];                  // Threshold bytes
   logic [7:0] user_r [0:ODSB_USER_BYTES-1];  // Customer area
   logic soft_txdis_r;                        // Software disable bit
   logic [15:0] rt_r [0:ODSB_NQ-1];           // Latched readings
   logic [7:0] alarm_r;
   logic [7:0] alarm_rx_r;
   logic [7:0] warn_r;
   logic [7:0] warn_rx_r;
   logic [2:0] pin_meta_r;                    // First synchroniser stage
   logic [2:0] pin_sync_r;                    // Second stage, safe to read
   logic [31:0] ready_cnt_r;
   logic ready_r;
   logic [7:0] rd_byte;
   logic [7:0] byte_adr;
   logic access;
   logic in_page;
   logic [ODSB_NQ-1:0] hi_a;
   logic [ODSB_NQ-1:0] lo_a;
   logic [ODSB_NQ-1:0] hi_w;
   logic [ODSB_NQ-1:0] lo_w;

   // Byte offset is word index; upper address bits must be zero
   assign byte_adr = wb_adr_i[9:2];
   assign in_page = (wb_adr_i[31:10] == 22'h000000);
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Fetch a 16-bit threshold for quantity q, slot s, MSB first
   function automatic logic [15:0] thr_word(input int q, input int s);
      thr_word = {thr_r[q*8+s*2], thr_r[q*8+s*2+1]};  // [R21]
   endfunction

   // Compare a reading with a threshold, signed for temperature
   function automatic logic above(input logic [15:0] a, input logic [15:0] b,
                                  input logic sgn);
      if (sgn)
      begin
         above = ($signed(a) > $signed(b));  // [R1] [R22]
      end
      else
      begin
         above = (a > b);
      end
   endfunction

   // ======================================================================
   // Pin synchronisers
   // ======================================================================
   // Rate select is deliberately not synchronised: it is never read
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end
      else
      begin
         pin_meta_r <= {tx_disable_pin, tx_fault_pin, receive_signal_lost_output};
         pin_sync_r <= pin_meta_r;
      end
   end

   // ======================================================================
   // Data ready timer
   // ======================================================================
   // Readings are treated as valid once the settle time has elapsed
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ready_cnt_r <= 32'h0;
         ready_r <= 1'b0;
      end
      else if (!ready_r)
      begin
         if (ready_cnt_r >= 32'(READY_CYC - 1))
         begin
            ready_r <= 1'b1;  // [R15]
         end
         ready_cnt_r <= ready_cnt_r + 32'h1;
      end
   end

   // ======================================================================
   // Live readings, encoded by the sensor front end
   // ======================================================================
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < ODSB_NQ; i++)
         begin
            rt_r[i] <= 16'h0;
         end
      end
      else
      begin
         rt_r[ODSB_Q_TEMP] <= temp_value;  // [R1]
         rt_r[ODSB_Q_VCC] <= vcc_value;    // [R2]
         rt_r[ODSB_Q_BIAS] <= bias_value;  // [R3]
         rt_r[ODSB_Q_TXP] <= txp_value;    // [R4]
         rt_r[ODSB_Q_RXP] <= rxp_value;    // [R5]
      end
   end

   // ======================================================================
   // Threshold comparison
   // ======================================================================
   // Flags are live levels, not latched; they follow the readings
   always_comb
   begin
      for (int q = 0; q < ODSB_NQ; q++)
      begin
         hi_a[q] = above(rt_r[q], thr_word(q, ODSB_T_HI_ALM), q == ODSB_Q_TEMP);
         lo_a[q] = above(thr_word(q, ODSB_T_LO_ALM), rt_r[q], q == ODSB_Q_TEMP);
         hi_w[q] = above(rt_r[q], thr_word(q, ODSB_T_HI_WRN), q == ODSB_Q_TEMP);
         lo_w[q] = above(thr_word(q, ODSB_T_LO_WRN), rt_r[q], q == ODSB_Q_TEMP);
      end
   end

   // Register the flag bytes; until data ready they stay clear
   always_ff @(posedge clk)
   begin
      if (!rstn || !ready_r)
      begin
         alarm_r <= 8'h00;
         alarm_rx_r <= 8'h00;
         warn_r <= 8'h00;
         warn_rx_r <= 8'h00;
      end
      else
      begin
         alarm_r <= {hi_a[0], lo_a[0], hi_a[1], lo_a[1],
                     hi_a[2], lo_a[2], hi_a[3], lo_a[3]};   // [R16] [R22]
         alarm_rx_r <= {hi_a[4], lo_a[4], 6'h00};          // [R17] [R23]
         warn_r <= {hi_w[0], lo_w[0], hi_w[1], lo_w[1],
                    hi_w[2], lo_w[2], hi_w[3], lo_w[3]};    // [R18] [R22]
         warn_rx_r <= {hi_w[4], lo_w[4], 6'h00};           // [R19] [R23]
      end
   end

   // ======================================================================
   // Writes: thresholds, soft disable, customer area
   // ======================================================================
   // Only lane 0 carries the byte; other lanes are ignored
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         soft_txdis_r <= ODSB_SOFT_TXDIS_RST;
      end
      else if (access && wb_we_i && wb_sel_i[0] && in_page
               && byte_adr == ODSB_PIN_STATUS_AND_SOFT_CONTROL)
      begin
         soft_txdis_r <= wb_dat_i[ODSB_ST_SOFT_TXDIS];  // [R11] [R23]
      end
   end

   // Threshold and customer bytes have no reset: host programs them
   always_ff @(posedge clk)
   begin
      if (access && wb_we_i && wb_sel_i[0] && in_page)
      begin
         if (byte_adr <= ODSB_THR_LAST)
         begin
            thr_r[byte_adr[5:0]] <= wb_dat_i[7:0];  // [R21]
         end
         if (byte_adr >= ODSB_USER_FIRST && byte_adr <= ODSB_USER_LAST)
         begin
            user_r[7'(byte_adr - ODSB_USER_FIRST)] <= wb_dat_i[7:0];  // [R8]
         end
      end
   end

   // ======================================================================
   // Read mux
   // ======================================================================
   always_comb
   begin
      rd_byte = ODSB_RSVD_READ;
      if (byte_adr <= ODSB_THR_LAST)
      begin
         rd_byte = thr_r[byte_adr[5:0]];
      end
      else if (byte_adr >= ODSB_CAL_FIRST && byte_adr <= ODSB_CAL_LAST)
      begin
         rd_byte = ODSB_CAL_DEFAULT;  // [R9]
      end
      else if (byte_adr == ODSB_PAGE_CHECKSUM)
      begin
         rd_byte = ODSB_CHECKSUM_DEFAULT;  // [R6]
      end
      else if (byte_adr >= ODSB_RT_FIRST && byte_adr <= ODSB_RT_LAST)
      begin
         // Even offset gives the high byte
         rd_byte = byte_adr[0] ? rt_r[byte_adr[3:1]][7:0]
                               : rt_r[byte_adr[3:1]][15:8];  // [R20]
      end
      else if (byte_adr == ODSB_PIN_STATUS_AND_SOFT_CONTROL)
      begin
         rd_byte[ODSB_ST_TXDIS_PIN] = pin_sync_r[2];  // [R10]
         rd_byte[ODSB_ST_SOFT_TXDIS] = soft_txdis_r;  // [R11]
         rd_byte[ODSB_ST_RATE] = 1'b1;                // [R12]
         rd_byte[ODSB_ST_TXFAULT] = pin_sync_r[1];    // [R13]
         rd_byte[ODSB_ST_LOS] = pin_sync_r[0];        // [R14]
         rd_byte[ODSB_ST_NOT_READY] = !ready_r;       // [R15]
      end
      else if (byte_adr == ODSB_ALARM_FLAGS_LOW_GROUP)
      begin
         rd_byte = alarm_r;
      end
      else if (byte_adr == ODSB_ALARM_FLAGS_RX_POWER)
      begin
         rd_byte = alarm_rx_r;
      end
      else if (byte_adr == ODSB_WARNING_FLAGS_LOW_GROUP)
      begin
         rd_byte = warn_r;
      end
      else if (byte_adr == ODSB_WARNING_FLAGS_RX_POWER)
      begin
         rd_byte = warn_rx_r;
      end
      else if (byte_adr >= ODSB_USER_FIRST && byte_adr <= ODSB_USER_LAST)
      begin
         rd_byte = user_r[7'(byte_adr - ODSB_USER_FIRST)];  // [R8]
      end
      // Legacy byte and other reserved bytes read zero
   end

   // ======================================================================
   // Bus answer
   // ======================================================================
   // One wait state: ack rises the cycle after the strobe, for one cycle.
   // Every address is acked, including the inert legacy byte; outside the
   // page reads give zero and writes are dropped.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= access;  // [R7]
         if (access && !wb_we_i)
         begin
            wb_dat_o <= in_page ? {24'h0, rd_byte} : 32'h0;  // [R23]
         end
      end
   end

   // ======================================================================
   // Transmitter disable
   // ======================================================================
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tx_off <= 1'b1;  // Safe: laser held off in reset
      end
      else
      begin
         tx_off <= pin_sync_r[2] || soft_txdis_r;  // [R11]
      end
   end
endmodule

// [core/odsb_pkg.sv]
/*
 Package for the diagnostic monitor page register bank: byte offsets,
 field positions, reset values and settle timing.
 Assumes a classic Wishbone slave with 32-bit data, one byte per word.
*/
package odsb_pkg;
   // =====================================================================
   // Page geometry
   // =====================================================================
   localparam int ODSB_PAGE_BYTES = 256;
   localparam logic [7:0] ODSB_THR_FIRST = 8'h00;      // Threshold pairs start
   localparam logic [7:0] ODSB_THR_LAST = 8'h27;       // Threshold pairs end
   localparam logic [7:0] ODSB_CAL_FIRST = 8'h37;      // Unused constants start
   localparam logic [7:0] ODSB_CAL_LAST = 8'h5e;       // Unused constants end
   localparam logic [7:0] ODSB_PAGE_CHECKSUM = 8'h5f;
   localparam logic [7:0] ODSB_RT_FIRST = 8'h60;       // Live readings start
   localparam logic [7:0] ODSB_RT_LAST = 8'h69;        // Live readings end
   localparam logic [7:0] ODSB_PIN_STATUS_AND_SOFT_CONTROL = 8'h6e;
   localparam logic [7:0] ODSB_ALARM_FLAGS_LOW_GROUP = 8'h70;
   localparam logic [7:0] ODSB_ALARM_FLAGS_RX_POWER = 8'h71;
   localparam logic [7:0] ODSB_WARNING_FLAGS_LOW_GROUP = 8'h74;
   localparam logic [7:0] ODSB_WARNING_FLAGS_RX_POWER = 8'h75;
   localparam logic [7:0] ODSB_LEGACY_INERT_BYTE = 8'h7f;
   localparam logic [7:0] ODSB_USER_FIRST = 8'h80;     // Writable area start
   localparam logic [7:0] ODSB_USER_LAST = 8'hf7;      // Writable area end
   localparam int ODSB_USER_BYTES = 120;
   // =====================================================================
   // Status byte fields
   // =====================================================================
   localparam int ODSB_ST_TXDIS_PIN = 7;
   localparam int ODSB_ST_SOFT_TXDIS = 6;
   localparam int ODSB_ST_RATE = 4;
   localparam int ODSB_ST_TXFAULT = 2;
   localparam int ODSB_ST_LOS = 1;
   localparam int ODSB_ST_NOT_READY = 0;
   // =====================================================================
   // Flag fields: quantity index q gives high at 7-2q, low at 6-2q
   // =====================================================================
   localparam int ODSB_Q_TEMP = 0;
   localparam int ODSB_Q_VCC = 1;
   localparam int ODSB_Q_BIAS = 2;
   localparam int ODSB_Q_TXP = 3;
   localparam int ODSB_Q_RXP = 4;
   localparam int ODSB_NQ = 5;
   // Threshold slot order within one quantity's 8 bytes
   localparam int ODSB_T_HI_ALM = 0;
   localparam int ODSB_T_LO_ALM = 1;
   localparam int ODSB_T_HI_WRN = 2;
   localparam int ODSB_T_LO_WRN = 3;
   // =====================================================================
   // Reset values and defaults (arbitrary, no identity meaning)
   // =====================================================================
   localparam logic [7:0] ODSB_CAL_DEFAULT = 8'h00;
   localparam logic [7:0] ODSB_CHECKSUM_DEFAULT = 8'h00;
   localparam logic [7:0] ODSB_RSVD_READ = 8'h00;
   localparam logic ODSB_SOFT_TXDIS_RST = 1'b0;
   // Sensor settle time before data ready, in microseconds
   localparam int ODSB_READY_US = 100;
   localparam int ODSB_CLK_MHZ = 100;
   localparam int ODSB_READY_CYC = ODSB_READY_US * ODSB_CLK_MHZ;
endpackage

// [dv/odsb_bank_chk.sv]
/*
 Checker for the diagnostic page bank: bus handshake, transmit-off path
 and fixed read fields.
 Assumes it is bound to odsb_bank and sees only that module's ports.
*/
`timescale 1ns/100ps
module odsb_bank_chk
   import odsb_pkg::*;
#(
   parameter int READY_CYC = 8
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic tx_disable_pin,
   input wire logic tx_off
);
   // ==================================================================
   // Clocking and steps
   // ==================================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Request waiting for its answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Completed read of one page byte
   sequence s_rd(logic [7:0] a);
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] == a;
   endsequence
   // Completed write that sets the soft disable bit
   sequence s_soft_wr;
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[ODSB_ST_SOFT_TXDIS]
         && wb_adr_i[9:2] == ODSB_PIN_STATUS_AND_SOFT_CONTROL;
   endsequence
   // ==================================================================
   // Properties
   // ==================================================================
   property p_ack_next;
      s_req |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack missing after request");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack longer than one cycle");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   // Reset must not be masked by the default disable
   property p_reset;
      disable iff (1'b0) !rstn |=> tx_off && !wb_ack_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("transmitter not held off in reset");
   property p_pin_hi;
      tx_disable_pin [*4] |-> tx_off;
   endproperty
   a_pin_hi: assert property (p_pin_hi)
      else $error("disable pin did not turn transmitter off");
   property p_pin_lo;
      !tx_off && $past(rstn, 3) |-> !$past(tx_disable_pin, 3);
   endproperty
   a_pin_lo: assert property (p_pin_lo)
      else $error("transmitter on while pin asserted");
   property p_soft;
      s_soft_wr |-> ##[1:2] tx_off;
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft disable ignored");
   property p_status;
      s_rd(ODSB_PIN_STATUS_AND_SOFT_CONTROL) |-> wb_dat_o[5:3] == 3'b010
         && wb_dat_o[31:8] == 24'h000000;
   endproperty
   a_status: assert property (p_status)
      else $error("status fixed bits wrong");
   property p_rsvd;
      wb_ack_o && !wb_we_i && (wb_adr_i[9:2] == ODSB_ALARM_FLAGS_RX_POWER
         || wb_adr_i[9:2] == ODSB_WARNING_FLAGS_RX_POWER) |-> wb_dat_o[5:0] == 6'h00;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved flag bits not zero");
   property p_cksum;
      s_rd(ODSB_PAGE_CHECKSUM) |-> wb_dat_o[7:0] == ODSB_CHECKSUM_DEFAULT;
   endproperty
   a_cksum: assert property (p_cksum)
      else $error("checksum byte changed");
endmodule
bind odsb_bank odsb_bank_chk #(.READY_CYC(READY_CYC)) u_chk (.clk, .rstn, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
   .tx_disable_pin, .tx_off);

// [dv/odsb_bank_tb.sv]
/*
 Self-checking bench for the diagnostic page bank.
 Assumes odsb_host as bus master and the bound checker.
*/
`timescale 1ns/100ps
module odsb_bank_tb;
   import odsb_pkg::*;
   localparam int RDY = 8; // Short settle time keeps the run brief
   localparam logic [7:0] ST = ODSB_PIN_STATUS_AND_SOFT_CONTROL;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] val [5] = '{default: 16'h0};
   logic dis_pin = 1'b0;
   logic rate_pin = 1'b0;
   logic flt_pin = 1'b0;
   logic los_pin = 1'b0;
   logic cyc, stb, we, ack, tx_off;
   logic [31:0] adr, wdat, rdat;
   logic [3:0] sel;
   logic [7:0] exp_q [$]; // Expected read bytes in issue order
   logic [7:0] thr [4] = '{8'h70, 8'h10, 8'h60, 8'h20}; // Thresholds, high byte
   logic [7:0] rb;
   int fail_count = 0;
   int comparisons = 0;
   int seed = 32'h8cb1;
   always #5 clk = ~clk;
   odsb_host u_host (.clk, .cyc, .stb, .we, .adr, .dat(wdat), .sel, .ack);
   odsb_bank #(.READY_CYC(RDY)) u_odsb_bank (.clk, .rstn, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .temp_value(val[0]),
      .vcc_value(val[1]), .bias_value(val[2]), .txp_value(val[3]),
      .rxp_value(val[4]), .tx_disable_pin(dis_pin), .rate_select_pin(rate_pin),
      .tx_fault_pin(flt_pin), .receive_signal_lost_output(los_pin), .tx_off);
   // ==================================================================
   // Helpers
   // ==================================================================
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task rd(input logic [7:0] off, input logic [7:0] exp);
      exp_q.push_back(exp);
      u_host.xfer(off, 1'b0, 8'h00, 1'b1);
   endtask
   task wr(input logic [7:0] off, input logic [7:0] d, input logic s = 1'b1);
      u_host.xfer(off, 1'b1, d, s);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Read answers checked against the oldest note, mid-cycle where settled
   always @(negedge clk)
      if (ack === 1'b1 && we === 1'b0)
         check(rdat, {24'h0, exp_q.pop_front()});
   // Watchdog well beyond the expected few thousand ns
   initial
   begin
      #20000;
      fail_count++;
      final_report;
   end
   // ==================================================================
   // Tests
   // ==================================================================
   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(ST, 8'h11);
      check({31'h0, tx_off}, 32'h0);
      repeat (RDY) @(posedge clk);
      rd(ST, 8'h10);
      $display("test ready done");
      dis_pin <= 1'b1;
      flt_pin <= 1'b1;
      los_pin <= 1'b1;
      rate_pin <= 1'($random(seed));
      repeat (4) @(posedge clk);
      rd(ST, 8'h96);
      check({31'h0, tx_off}, 32'h1);
      dis_pin <= 1'b0;
      flt_pin <= 1'b0;
      los_pin <= 1'b0;
      wr(ST, 8'hff);
      rd(ST, 8'h50);
      check({31'h0, tx_off}, 32'h1);
      wr(ST, 8'h00);
      repeat (3) @(posedge clk);
      check({31'h0, tx_off}, 32'h0);
      $display("test pins done");
      for (int i = 0; i < 5; i++)
         val[i] <= 16'($random(seed));
      repeat (2) @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         rd(ODSB_RT_FIRST + 8'(2 * i), val[i][15:8]);
         rd(ODSB_RT_FIRST + 8'(2 * i + 1), val[i][7:0]);
      end
      $display("test readings done");
      for (int q = 0; q < 5; q++)
         for (int s = 0; s < 4; s++)
         begin
            wr(8'(q * 8 + s * 2), thr[s]);
            wr(8'(q * 8 + s * 2 + 1), 8'h00);
         end
      val <= '{16'h9000, 16'h7100, 16'h6500, 16'h1800, 16'h0800};
      repeat (3) @(posedge clk);
      rd(8'h10, 8'h70);
      rd(ODSB_ALARM_FLAGS_LOW_GROUP, 8'h60);
      rd(ODSB_ALARM_FLAGS_RX_POWER, 8'h40);
      rd(ODSB_WARNING_FLAGS_LOW_GROUP, 8'h69);
      rd(ODSB_WARNING_FLAGS_RX_POWER, 8'h40);
      wr(ODSB_ALARM_FLAGS_LOW_GROUP, 8'hff);
      rd(ODSB_ALARM_FLAGS_LOW_GROUP, 8'h60);
      $display("test flags done");
      rb = 8'($random(seed));
      wr(ODSB_USER_FIRST, rb);
      wr(ODSB_USER_LAST, ~rb);
      wr(ODSB_USER_FIRST, ~rb, 1'b0);
      wr(ODSB_LEGACY_INERT_BYTE, 8'hff);
      rate_pin <= ~rate_pin; // Other rate level must not show either
      rd(ODSB_USER_FIRST, rb);
      rd(ODSB_USER_LAST, ~rb);
      rd(ST, 8'h10);
      check({31'h0, tx_off}, 32'h0);
      rd(ODSB_CAL_FIRST, ODSB_CAL_DEFAULT);
      rd(ODSB_CAL_LAST, ODSB_CAL_DEFAULT);
      rd(ODSB_PAGE_CHECKSUM, ODSB_CHECKSUM_DEFAULT);
      rd(8'h72, ODSB_RSVD_READ);
      $display("test page done");
      repeat (2) @(posedge clk);
      final_report;
   end
endmodule

// [dv/odsb_host.sv]
/*
 Host controller model: a classic Wishbone master with one transfer task.
 Assumes the bench calls the task just after a rising edge.
*/
`timescale 1ns/100ps
module odsb_host (
   input wire logic clk,
   output logic cyc = 1'b0,
   output logic stb = 1'b0,
   output logic we = 1'b0,
   output logic [31:0] adr = 32'h0,
   output logic [31:0] dat = 32'h0,
   output logic [3:0] sel = 4'h0,
   input wire logic ack
);
   // ==================================================================
   // Single transfer, held until ack, then one idle cycle
   // ==================================================================
   task automatic xfer(input logic [7:0] off, input logic w, input logic [7:0] d,
                       input logic s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {22'h0, off, 2'b00};
      dat <= {24'h0, d};
      sel <= {3'b000, s};
      @(posedge clk);
      // Bench watchdog bounds this wait
      while (ack !== 1'b1)
         @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // Released lines do not keep their last value
      adr <= ~adr;
      dat <= ~dat;
      @(posedge clk);
   endtask
endmodule
